// file: hdl/qdsi_pkg.sv
// constants shared by the quad converter serial write front end
package qdsi_pkg;
  // frame shape
  localparam int FRAME_BITS = 24;
  localparam int CHANNELS = 4;
  localparam int CODE_BITS = 16;
  localparam int CNT_BITS = 5;
  localparam logic [4:0] LAST_BIT_IDX = 5'h17;
  localparam logic [4:0] FULL_COUNT = 5'h18;
  // word layout: [23:22] device address, [21:18] unused, [17:16] channel, [15:0] code
  localparam int ADDR_MSB = 23;
  localparam int ADDR_LSB = 22;
  localparam int CHAN_MSB = 17;
  localparam int CHAN_LSB = 16;
  localparam int CODE_MSB = 15;
  localparam int CODE_LSB = 0;
  // reset values
  localparam logic [15:0] CODE_RESET = 16'h0000;
  // buffer shape
  localparam int FIFO_DEPTH = 4;
  // synchroniser length
  localparam int SYNC_STAGES = 2;
endpackage : qdsi_pkg

// file: hdl/qdsi_top.sv
// serial write front end of a four channel converter, with its crossing buffer
`timescale 1ns/1ns

// overview of the two clock domains
// - link side runs on the falling shift clock from the host
// - system side runs on i_sys_clk and owns every top-level output
// - a small dual clock buffer with gray pointers joins the two
// link side in short
// - frame select low and interface enable low open the port
// - each open falling edge shifts one data bit, msb first
// - the 24th open edge hands the whole word to the buffer
// - further edges in the same frame are ignored until frame select rises
// - frame select high clears the bit count at once, so a cut frame is lost
// system side in short
// - a word is taken from the buffer whenever one is waiting
// - its address field is held against the synchronised address straps
// - a match writes the channel buffer and the converter code together
// - a rising load pin copies all four buffers into the converter codes
// - a load edge wins over a word in the same cycle; the word waits one cycle
// reset in short
// - i_rst_n is synchronous and resets the system side directly
// - the link side sees it through two falling shift clock stages
// - the host must therefore toggle the shift clock during reset
// - frame select must stay high during reset so no frame is half taken
// limitations a user must know
// - the buffer holds four words; a fifth back-to-back frame is dropped
// - a dropped word is reported as a one cycle pulse, not stored
// - address straps are sampled continuously; change them only when idle
// - the load pin needs one system cycle high and one low to be seen
// trade-offs
// - the shifter is never cleared; the count alone marks valid bits
// - this saves a reset path on the fast link clock
// - pointers cross in gray code so a stale value is safe, only pessimistic

// dual clock word buffer with gray coded pointers
module qdsi_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic i_wr_clk,
  input wire logic i_wr_rst_n,
  input wire logic i_wr_valid,
  output logic o_wr_ready,
  input wire logic [WIDTH-1:0] i_wr_data,
  input wire logic i_rd_clk,
  input wire logic i_rd_rst_n,
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [WIDTH-1:0] o_rd_data
);
  localparam int AW = $clog2(DEPTH);

  // pointer compare below needs at least two address bits
  if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("qdsi_fifo: DEPTH must be a power of two, at least 4");
  end

  // pointers carry one extra wrap bit
  // - equal pointers mean empty
  // - pointers differing only in the top two gray bits mean full
  // the memory itself has no reset; valid is decided by the pointers

  function automatic logic [AW:0] qdsi_bin2gray(input logic [AW:0] b);
    qdsi_bin2gray = b ^ (b >> 1);
  endfunction : qdsi_bin2gray

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wbin;
  logic [AW:0] wgray;
  logic [AW:0] rbin;
  logic [AW:0] rgray;
  logic [AW:0] rgray_m;
  logic [AW:0] rgray_s;
  logic [AW:0] wgray_m;
  logic [AW:0] wgray_s;
  logic full;
  logic empty;
  logic [AW:0] next_wbin;
  logic [AW:0] next_rbin;

  // full when write gray is read gray with top two bits inverted
  assign full = (wgray == {~rgray_s[AW:AW-1], rgray_s[AW-2:0]});
  assign empty = (rgray == wgray_s);
  assign o_wr_ready = ~full;
  assign o_rd_valid = ~empty;
  assign o_rd_data = mem[rbin[AW-1:0]];
  assign next_wbin = wbin + {{AW{1'b0}}, 1'b1};
  assign next_rbin = rbin + {{AW{1'b0}}, 1'b1};

  // write side: store word and advance pointer
  always_ff @(posedge i_wr_clk) begin
    if (!i_wr_rst_n) begin
      wbin <= '0;
      wgray <= '0;
    end else if (i_wr_valid && !full) begin
      mem[wbin[AW-1:0]] <= i_wr_data;
      wbin <= next_wbin;
      wgray <= qdsi_bin2gray(next_wbin);
    end
  end

  // read pointer into write domain; stale value only makes full pessimistic
  always_ff @(posedge i_wr_clk) begin
    if (!i_wr_rst_n) begin
      rgray_m <= '0;
      rgray_s <= '0;
    end else begin
      rgray_m <= rgray;
      rgray_s <= rgray_m;
    end
  end

  // read side: advance on handshake
  always_ff @(posedge i_rd_clk) begin
    if (!i_rd_rst_n) begin
      rbin <= '0;
      rgray <= '0;
    end else if (i_rd_ready && !empty) begin
      rbin <= next_rbin;
      rgray <= qdsi_bin2gray(next_rbin);
    end
  end

  // write pointer into read domain
  always_ff @(posedge i_rd_clk) begin
    if (!i_rd_rst_n) begin
      wgray_m <= '0;
      wgray_s <= '0;
    end else begin
      wgray_m <= wgray;
      wgray_s <= wgray_m;
    end
  end
endmodule : qdsi_fifo

// Contract
// - while frame select low, shift register enabled, data sampled on falling shift clock
// - shift register is 24 bits, one bit per falling shift-clock edge
// - after the 24th edge the word updates the addressed converter output
// - frame select rising before the 24th edge discards the partial write
// - serial port is connected only while interface enable is low
// - load pin rising edge copies all buffered codes into converter registers together
// - device address comes from two address-select pins
module qdsi_top #(
  parameter int FIFO_DEPTH = qdsi_pkg::FIFO_DEPTH
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_frame_sel_n,
  input wire logic i_sdata,
  input wire logic i_if_enable_n,
  input wire logic i_load_all_outputs,
  input wire logic i_addr_pin_0,
  input wire logic i_addr_pin_1,
  output logic [qdsi_pkg::CHANNELS*qdsi_pkg::CODE_BITS-1:0] o_conv_code,
  output logic [qdsi_pkg::CHANNELS-1:0] o_conv_update,
  output logic o_frame_dropped
);
  localparam int CB = qdsi_pkg::CODE_BITS;
  localparam int NCH = qdsi_pkg::CHANNELS;

  // buffer pointer logic cannot serve fewer than four words
  if (FIFO_DEPTH < 4) begin : g_bad_depth
    $error("qdsi_top: FIFO_DEPTH must be at least 4");
  end

  // address match, used by both the buffer and the converter writes
  function automatic logic qdsi_addr_hit(input logic [1:0] a, input logic [1:0] s);
    return a == s;
  endfunction : qdsi_addr_hit

  // ---------------- link domain, falling shift clock ----------------
  logic sclk_n;
  logic [qdsi_pkg::SYNC_STAGES-1:0] link_rst_pipe;
  logic link_rst_n;
  logic [qdsi_pkg::FRAME_BITS-2:0] shift_reg;
  logic [qdsi_pkg::CNT_BITS-1:0] bit_cnt;
  logic port_open;
  logic last_bit;
  logic wr_valid;
  logic wr_ready;
  logic [qdsi_pkg::FRAME_BITS-1:0] wr_word;
  logic drop_toggle;

  // buffer writes on the falling shift clock edge
  assign sclk_n = ~i_sclk;
  assign link_rst_n = link_rst_pipe[qdsi_pkg::SYNC_STAGES-1];
  assign port_open = ~i_frame_sel_n & ~i_if_enable_n;
  assign last_bit = (bit_cnt == qdsi_pkg::LAST_BIT_IDX);
  assign wr_valid = port_open & last_bit;
  assign wr_word = {shift_reg, i_sdata};

  // reset carried into link domain; needs shift clock edges during reset
  always_ff @(negedge i_sclk) begin
    link_rst_pipe <= {link_rst_pipe[qdsi_pkg::SYNC_STAGES-2:0], i_rst_n};
  end

  // frame select high holds count at zero: abort and fresh start in one place
  always_ff @(negedge i_sclk or posedge i_frame_sel_n) begin
    if (i_frame_sel_n) begin
      bit_cnt <= '0;
    end else if (!i_if_enable_n && bit_cnt != qdsi_pkg::FULL_COUNT) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  // shifter itself is never cleared; the count decides what is valid
  always_ff @(negedge i_sclk) begin
    if (port_open && bit_cnt != qdsi_pkg::FULL_COUNT) begin
      shift_reg <= {shift_reg[qdsi_pkg::FRAME_BITS-3:0], i_sdata};
    end
  end

  // full frame with no room: word lost, reported as an event
  always_ff @(negedge i_sclk) begin
    if (!link_rst_n) begin
      drop_toggle <= 1'b0;
    end else if (wr_valid && !wr_ready) begin
      drop_toggle <= ~drop_toggle;
    end
  end

  // ---------------- crossing buffer ----------------
  logic rd_valid;
  logic rd_ready;
  logic [qdsi_pkg::FRAME_BITS-1:0] rd_word;

  qdsi_fifo #(
    .WIDTH(qdsi_pkg::FRAME_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_wr_clk(sclk_n),
    .i_wr_rst_n(link_rst_n),
    .i_wr_valid(wr_valid),
    .o_wr_ready(wr_ready),
    .i_wr_data(wr_word),
    .i_rd_clk(i_sys_clk),
    .i_rd_rst_n(i_rst_n),
    .o_rd_valid(rd_valid),
    .i_rd_ready(rd_ready),
    .o_rd_data(rd_word)
  );

  // ---------------- system domain ----------------
  logic [2:0] load_sync;
  logic [1:0] addr_m;
  logic [1:0] addr_s;
  logic [2:0] drop_sync;
  logic load_rise;
  logic [1:0] word_addr;
  logic [1:0] word_chan;
  logic [CB-1:0] word_code;
  logic take_word;
  logic word_hit;
  logic [CB-1:0] buf_code [NCH];

  // load pin, address straps and drop event: two flops before use
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      load_sync <= 3'h0;
      addr_m <= 2'h0;
      addr_s <= 2'h0;
      drop_sync <= 3'h0;
    end else begin
      load_sync <= {load_sync[1:0], i_load_all_outputs};
      addr_m <= {i_addr_pin_1, i_addr_pin_0};
      addr_s <= addr_m;
      drop_sync <= {drop_sync[1:0], drop_toggle};
    end
  end

  assign load_rise = load_sync[1] & ~load_sync[2];
  // a load edge takes the cycle; pending word waits, which back-pressures the buffer
  assign rd_ready = ~load_rise;
  assign take_word = rd_valid & rd_ready;
  assign word_addr = rd_word[qdsi_pkg::ADDR_MSB:qdsi_pkg::ADDR_LSB];
  assign word_chan = rd_word[qdsi_pkg::CHAN_MSB:qdsi_pkg::CHAN_LSB];
  assign word_code = rd_word[qdsi_pkg::CODE_MSB:qdsi_pkg::CODE_LSB];
  // words for other devices are read and thrown away, never stall the buffer
  assign word_hit = take_word & qdsi_addr_hit(word_addr, addr_s);

  // buffered codes: written by every frame aimed at this device
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      for (int i = 0; i < NCH; i++) begin
        buf_code[i] <= qdsi_pkg::CODE_RESET;
      end
    end else if (word_hit) begin
      buf_code[word_chan] <= word_code;
    end
  end

  // converter registers: load edge copies all, a frame updates its channel
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_conv_code <= {NCH{qdsi_pkg::CODE_RESET}};
      o_conv_update <= '0;
    end else if (load_rise) begin
      for (int i = 0; i < NCH; i++) begin
        o_conv_code[i*CB +: CB] <= buf_code[i];
      end
      o_conv_update <= {NCH{1'b1}};
    end else if (word_hit) begin
      o_conv_code[word_chan*CB +: CB] <= word_code;
      o_conv_update <= 4'h1 << word_chan;
    end else begin
      o_conv_update <= '0;
    end
  end

  // one-cycle pulse per lost frame
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_frame_dropped <= 1'b0;
    end else begin
      o_frame_dropped <= drop_sync[1] ^ drop_sync[2];
    end
  end
endmodule : qdsi_top

// file: tb/qdsi_props.sv
// checker for the serial write front end ports
`timescale 1ns/1ns
module qdsi_props (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_sclk,
  input wire logic i_frame_sel_n,
  input wire logic i_sdata,
  input wire logic i_if_enable_n,
  input wire logic i_load_all_outputs,
  input wire logic i_addr_pin_0,
  input wire logic i_addr_pin_1,
  input wire logic [63:0] o_conv_code,
  input wire logic [3:0] o_conv_update,
  input wire logic o_frame_dropped
);
  logic [3:0] en_hi;
  logic [3:0] fs_hi;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // quiet-time counters, saturating so long idles never wrap
  always_ff @(posedge i_sys_clk) begin
    en_hi <= (!i_rst_n || !i_if_enable_n) ? 4'h0 : en_hi + {3'h0, en_hi != 4'hf};
    fs_hi <= (!i_rst_n || !i_frame_sel_n) ? 4'h0 : fs_hi + {3'h0, fs_hi != 4'hf};
  end
  property p_upd_shape; $onehot0(o_conv_update) || o_conv_update == 4'hf; endproperty
  a_upd_shape: assert property (p_upd_shape)
    else $error("update pulse malformed");
  property p_code_hold; !$stable(o_conv_code) |-> o_conv_update != 4'h0; endproperty
  a_code_hold: assert property (p_code_hold)
    else $error("code moved without update");
  property p_load_resp; $rose(i_load_all_outputs) |-> ##[1:4] o_conv_update == 4'hf; endproperty
  a_load_resp: assert property (p_load_resp)
    else $error("load edge gave no full update");
  property p_load_cause; o_conv_update == 4'hf |-> $past(i_load_all_outputs, 2); endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("full update without load");
  property p_en_gate; en_hi >= 4'ha |-> o_conv_update inside {4'h0, 4'hf}; endproperty
  a_en_gate: assert property (p_en_gate)
    else $error("write while interface disabled");
  property p_fs_gate; fs_hi >= 4'ha |-> o_conv_update inside {4'h0, 4'hf}; endproperty
  a_fs_gate: assert property (p_fs_gate)
    else $error("write without frame");
  property p_drop_pulse; o_frame_dropped |=> !o_frame_dropped; endproperty
  a_drop_pulse: assert property (p_drop_pulse)
    else $error("drop flag longer than one cycle");
  property p_drop_gate; o_frame_dropped |-> en_hi < 4'h8; endproperty
  a_drop_gate: assert property (p_drop_gate)
    else $error("drop while interface disabled");
  c_load: cover property (o_conv_update == 4'hf);
  c_chan: cover property ($onehot(o_conv_update));
  c_abort: cover property (fs_hi == 4'h2 && en_hi == 4'h0);
endmodule : qdsi_props
bind qdsi_top qdsi_props u_qdsi_props (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk),
  .i_frame_sel_n(i_frame_sel_n), .i_sdata(i_sdata), .i_if_enable_n(i_if_enable_n),
  .i_load_all_outputs(i_load_all_outputs), .i_addr_pin_0(i_addr_pin_0), .i_addr_pin_1(i_addr_pin_1),
  .o_conv_code(o_conv_code), .o_conv_update(o_conv_update), .o_frame_dropped(o_frame_dropped));

// file: tb/qdsi_host.sv
// host model driving the three wire serial write link
`timescale 1ns/1ns
module qdsi_host (
  output logic o_sclk,
  output logic o_frame_sel_n,
  output logic o_sdata,
  output logic o_if_enable_n
);
  // idle link: clock high, frame and enable off
  initial begin
    o_sclk = 1'b1;
    o_frame_sel_n = 1'b1;
    o_sdata = 1'b0;
    o_if_enable_n = 1'b1;
  end
  // clocks with frame select high, only for the reset hand-over
  task automatic idle(input int n);
    repeat (n) begin
      #16 o_sclk = 1'b0;
      #16 o_sclk = 1'b1;
    end
  endtask : idle
  // msb first; data set while clock is high so it is steady at the falling edge
  task automatic send(input logic [23:0] w, input int n, input logic en_n);
    o_if_enable_n = en_n;
    #17 o_frame_sel_n = 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      o_sdata = w[i];
      #16 o_sclk = 1'b0;
      #16 o_sclk = 1'b1;
    end
    #16 o_frame_sel_n = 1'b1;
    o_sdata = ~o_sdata; // released line keeps no stale value
    #4 o_if_enable_n = 1'b1;
    #20;
  endtask : send
endmodule : qdsi_host

// file: tb/quad_dac_serial_input_tb.sv
// self-checking bench for the quad converter serial write front end
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; $display("wrong value at %0t: got %h, expected %h", $time, g, e); end end
module quad_dac_serial_input_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic load = 1'b0;
  logic [1:0] straps;
  wire sclk, fs_n, sdata, en_n;
  logic [63:0] code;
  logic [3:0] upd;
  logic drop;
  logic drops = 1'b0;
  logic [3:0] seen = 4'h0;
  logic [15:0] exp_code [4];
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  qdsi_top u_qdsi_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_frame_sel_n(fs_n),
    .i_sdata(sdata), .i_if_enable_n(en_n), .i_load_all_outputs(load), .i_addr_pin_0(straps[0]),
    .i_addr_pin_1(straps[1]), .o_conv_code(code), .o_conv_update(upd), .o_frame_dropped(drop));
  qdsi_host u_qdsi_host (.o_sclk(sclk), .o_frame_sel_n(fs_n), .o_sdata(sdata), .o_if_enable_n(en_n));
  // clock generation
  initial forever #5 clk = ~clk;
  // pulses are gathered here so none is missed while a frame is on the wire
  always @(posedge clk) begin
    seen <= seen | upd;
    drops <= drops | drop;
    cyc++;
    if (cyc == 6000) begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  // word layout: address, unused, channel, code
  function automatic logic [23:0] mk(input logic [1:0] a, input logic [1:0] ch, input logic [15:0] c);
    return {a, 4'h0, ch, c};
  endfunction : mk
  function automatic logic [63:0] all_exp();
    return {exp_code[3], exp_code[2], exp_code[1], exp_code[0]};
  endfunction : all_exp
  // one frame, then the expected update bit and code image
  task automatic frame(input logic [1:0] a, input logic [1:0] ch, input logic [15:0] c, input int n,
                       input logic e);
    logic [3:0] want;
    want = (a == straps && n == 24 && !e) ? 4'h1 << ch : 4'h0;
    if (want != 4'h0) exp_code[ch] = c;
    seen = 4'h0;
    u_qdsi_host.send(mk(a, ch, c), n, e);
    repeat (12) @(posedge clk);
    #1 `CHK(seen, want)
    `CHK(code, all_exp())
  endtask : frame
  initial begin
    void'($urandom(22266));
    straps = 2'($urandom);
    for (int i = 0; i < 4; i++) exp_code[i] = 16'h0000;
    fork
      u_qdsi_host.idle(4);
      repeat (5) @(posedge clk);
    join
    @(posedge clk) #1 rst_n = 1'b1;
    `CHK(code, 64'h0)
    u_qdsi_host.idle(3);
    frame(straps, 2'h0, 16'h0000, 24, 1'b0);
    frame(straps, 2'h3, 16'hffff, 24, 1'b0);
    for (int i = 0; i < 8; i++) frame(straps, 2'($urandom), 16'($urandom), 24, 1'b0);
    frame(straps, 2'($urandom), 16'($urandom), 1 + $urandom % 23, 1'b0);
    frame(straps ^ 2'h1, 2'h1, 16'h5a5a, 24, 1'b0);
    frame(straps, 2'h2, 16'ha5a5, 23, 1'b0);
    frame(straps, 2'h2, 16'h1234, 1, 1'b0);
    frame(straps, 2'h2, 16'h4321, 24, 1'b0);
    frame(straps, 2'h1, 16'h0f0f, 24, 1'b1);
    straps = ~straps;
    repeat (4) @(posedge clk);
    frame(straps, 2'h1, 16'hbeef, 24, 1'b0);
    seen = 4'h0;
    load = 1'b1;
    repeat (4) @(posedge clk);
    #1 load = 1'b0;
    repeat (6) @(posedge clk);
    #1 `CHK(seen, 4'hf)
    `CHK(code, all_exp())
    `CHK(drops, 1'b0)
    conclude();
  end
endmodule : quad_dac_serial_input_tb
